// file: hdl/vic_map.svh
// register map, field positions, reset values and sizes of the interrupt controller
`ifndef VIC_MAP_SVH
`define VIC_MAP_SVH

// sizes
`define VIC_NREQ 6
`define VIC_RANK_W 3
`define VIC_ADDR_W 12
`define VIC_DATA_W 32

// register indexes; byte address is four times the index
`define VIC_IDX_PIN 8'hF8
`define VIC_IDX_PRIO 8'hF9
`define VIC_IDX_REQ 8'hFA
`define VIC_IDX_MASK 8'hFB
`define VIC_IDX_CFG 8'hFC

// request and edge register fields
`define VIC_REQ_PEND_LSB 0
`define VIC_REQ_EDGE_TWO 6
`define VIC_REQ_EDGE_ONE 7

// mask register fields
`define VIC_MASK_EN_LSB 0
`define VIC_MASK_GLOBAL 7

// config register fields
`define VIC_CFG_COMP 0

// request numbers of each source
`define VIC_REQ_ZERO 0
`define VIC_REQ_ONE 1
`define VIC_REQ_TWO 2
`define VIC_REQ_THREE 3
`define VIC_REQ_FOUR 4
`define VIC_REQ_FIVE 5

// reset values
`define VIC_RST_REQ 8'h00
`define VIC_RST_MASK 8'h00
`define VIC_RST_CFG 1'b0
`define VIC_RST_PRIO 18'h2C688

`endif

// file: hdl/vic_pkg.sv
// types shared by the interrupt controller modules
package vic_pkg;
    // one priority rank per request, smaller wins
    typedef logic [2:0] vic_rank_t;
    typedef vic_rank_t [5:0] vic_ranks_t;
    // result of the priority selection
    typedef struct packed {
        logic valid;
        logic [2:0] idx;
    } vic_sel_t;
    // pin and comparator inputs that feed requests
    typedef struct packed {
        logic port_pin_one;
        logic port_pin_two;
        logic port_pin_three;
        logic comparator_one_out;
        logic comparator_two_out;
    } vic_pins_t;
endpackage : vic_pkg

// file: hdl/vic_edge_det.sv
// optional two-stage synchroniser and selectable edge detector
module vic_edge_det #(
    parameter bit SYNC = 1'b1
) (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // signal and edge choice
    input logic sig_in,
    input logic rise_en,
    input logic fall_en,
    // results
    output logic level,
    output logic evt
);
    import vic_pkg::*;

    logic prev_reg;

    // ==========================================================
    // input stage
    generate
        if (SYNC) begin : g_sync
            logic s1_reg;
            logic s2_reg;
            // first stage feeds only the second
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    // idle level is high, same as prev_reg, so reset makes no edge
                    s1_reg <= 1'b1;
                    s2_reg <= 1'b1;
                end else begin
                    s1_reg <= sig_in;
                    s2_reg <= s1_reg;
                end
            end
            assign level = s2_reg;
        end else begin : g_nosync
            assign level = sig_in;
        end
    endgenerate

    // ==========================================================
    // edge detection
    // reset to the idle high level, like the synchroniser, so reset release makes no edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= level;
        end
    end

    assign evt = (rise_en & level & ~prev_reg) | (fall_en & ~level & prev_reg);
endmodule : vic_edge_det

// file: hdl/vic_prio_enc.sv
// programmable priority encoder: lowest rank wins, ties go to the lower request
module vic_prio_enc #(
    parameter int NREQ = 6
) (
    // candidates
    input logic [NREQ-1:0] req,
    input vic_pkg::vic_ranks_t ranks,
    // winner
    output vic_pkg::vic_sel_t sel
);
    import vic_pkg::*;

    // linear scan keeps the first minimum, so ties fall to the lower index
    always_comb begin
        vic_rank_t best;
        best = '1;
        sel = '0;
        for (int i = 0; i < NREQ; i++) begin
            if (req[i] && (!sel.valid || ranks[i] < best)) begin
                best = ranks[i];
                sel.valid = 1'b1;
                sel.idx = 3'(i);
            end
        end
    end
endmodule : vic_prio_enc

// file: hdl/vic_top.sv
// vectored interrupt controller with apb register access
`include "vic_map.svh"

module vic_top (
    // apb slave
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request sources
    input vic_pkg::vic_pins_t pins,
    input logic dsp_request,
    input logic timer_zero_end,
    input logic timer_one_end,
    // processor core side
    input logic int_ack,
    input logic int_reenable,
    input logic halt_active,
    output logic int_req,
    output logic [15:0] vector_addr,
    output logic int_cycle,
    output logic halt_wake,
    output logic irq
);
    import vic_pkg::*;

    localparam int NREQ = `VIC_NREQ;

    // ==========================================================
    // registers and wires
    logic [7:0] req_reg;
    logic [7:0] mask_reg;
    logic cfg_comp_reg;
    vic_ranks_t prio_reg;
    logic [31:0] prdata_reg;
    logic [15:0] vector_reg;
    vic_sel_t sel_reg;
    logic cycle_reg;
    logic [NREQ-1:0] pend_next;
    logic [NREQ-1:0] evt_vec;
    logic [NREQ-1:0] enabled_vec;
    logic [NREQ-1:0] ack_clr;
    logic [NREQ-1:0] w1c;
    logic [9:0] word_addr;
    logic wr_req;
    logic rd_setup;
    logic hit;
    logic ack_take;
    logic src_zero;
    logic src_two;
    logic lvl_zero;
    logic lvl_one;
    logic lvl_two;
    logic lvl_dsp;
    logic edge_one_sel;
    logic edge_two_sel;
    vic_sel_t sel_now;
    vic_pins_t pin_s1_reg;
    vic_pins_t pin_s2_reg;
    logic [31:0] rd_mux;

    // ==========================================================
    // apb decode
    // zero wait states: read data is caught in the setup cycle
    assign word_addr = paddr[11:2];
    assign hit = (word_addr == {2'b00, `VIC_IDX_PIN}) || (word_addr == {2'b00, `VIC_IDX_PRIO})
        || (word_addr == {2'b00, `VIC_IDX_REQ}) || (word_addr == {2'b00, `VIC_IDX_MASK})
        || (word_addr == {2'b00, `VIC_IDX_CFG});
    assign wr_req = psel & penable & pwrite & hit;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = prdata_reg;

    // read mux; unmapped words and reserved bits read zero
    always_comb begin
        rd_mux = '0;
        unique case (word_addr)
            {2'b00, `VIC_IDX_PIN}: rd_mux = {27'h0000000, 1'b0, lvl_one,
                lvl_zero, lvl_two, lvl_dsp};
            {2'b00, `VIC_IDX_PRIO}: rd_mux = {14'h0000, prio_reg};
            {2'b00, `VIC_IDX_REQ}: rd_mux = {24'h000000, req_reg};
            {2'b00, `VIC_IDX_MASK}: rd_mux = {24'h000000, mask_reg};
            {2'b00, `VIC_IDX_CFG}: rd_mux = {31'h00000000, cfg_comp_reg};
            default: rd_mux = '0;
        endcase
    end

    // read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
        end else if (rd_setup) begin
            prdata_reg <= rd_mux;
        end
    end

    // ==========================================================
    // request sources
    // two flops on every pin and comparator line before any logic looks at it;
    // they reset to the idle high level, so releasing reset makes no edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= '1;
            pin_s2_reg <= '1;
        end else begin
            pin_s1_reg <= pins;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // comparator mode swaps the pin for its comparator; swapping may fake one edge
    assign src_two = cfg_comp_reg ? pin_s2_reg.comparator_one_out
        : pin_s2_reg.port_pin_one;
    assign src_zero = cfg_comp_reg ? pin_s2_reg.comparator_two_out
        : pin_s2_reg.port_pin_two;
    // edge choice: bit 7 steers pin one, bit 6 steers pin two
    assign edge_one_sel = req_reg[`VIC_REQ_EDGE_ONE];
    assign edge_two_sel = req_reg[`VIC_REQ_EDGE_TWO];

    // request zero: pin two or second comparator, programmable edges
    vic_edge_det #(.SYNC(1'b0)) u_edge_zero (
        .clk(pclk),
        .rst_n(presetn),
        .sig_in(src_zero),
        .rise_en(edge_two_sel),
        .fall_en(~edge_two_sel | edge_one_sel),
        .level(lvl_zero),
        .evt(evt_vec[`VIC_REQ_ZERO])
    );

    // request one: pin three, falling edge only
    vic_edge_det #(.SYNC(1'b0)) u_edge_one (
        .clk(pclk),
        .rst_n(presetn),
        .sig_in(pin_s2_reg.port_pin_three),
        .rise_en(1'b0),
        .fall_en(1'b1),
        .level(lvl_one),
        .evt(evt_vec[`VIC_REQ_ONE])
    );

    // request two: pin one or first comparator, programmable edges
    vic_edge_det #(.SYNC(1'b0)) u_edge_two (
        .clk(pclk),
        .rst_n(presetn),
        .sig_in(src_two),
        .rise_en(edge_one_sel),
        .fall_en(~edge_one_sel | edge_two_sel),
        .level(lvl_two),
        .evt(evt_vec[`VIC_REQ_TWO])
    );

    // request three: dsp line on this clock, so no synchroniser
    vic_edge_det #(.SYNC(1'b0)) u_edge_dsp (
        .clk(pclk),
        .rst_n(presetn),
        .sig_in(dsp_request),
        .rise_en(1'b0),
        .fall_en(1'b1),
        .level(lvl_dsp),
        .evt(evt_vec[`VIC_REQ_THREE])
    );

    // timer end-of-count pulses are already on this clock
    assign evt_vec[`VIC_REQ_FOUR] = timer_zero_end;
    assign evt_vec[`VIC_REQ_FIVE] = timer_one_end;

    // ==========================================================
    // pending bits
    assign ack_take = int_ack & sel_reg.valid;
    assign ack_clr = ack_take ? (NREQ'(1) << sel_reg.idx) : '0;
    assign w1c = wr_req && (word_addr == {2'b00, `VIC_IDX_REQ}) ? pwdata[NREQ-1:0] : '0;
    // new events win over both software and acknowledge clears
    assign pend_next = (req_reg[NREQ-1:0] & ~w1c & ~ack_clr) | evt_vec;

    // request register: pending bits latch even while masked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg <= `VIC_RST_REQ;
        end else begin
            req_reg[NREQ-1:0] <= pend_next;
            if (wr_req && (word_addr == {2'b00, `VIC_IDX_REQ})) begin
                req_reg[7:6] <= pwdata[7:6];
            end
        end
    end

    // ==========================================================
    // mask, priority and config registers
    // grant drops the global enable; the core's return or software raises it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= `VIC_RST_MASK;
        end else begin
            if (wr_req && (word_addr == {2'b00, `VIC_IDX_MASK})) begin
                mask_reg <= {pwdata[7], 1'b0, pwdata[5:0]};
            end else if (int_reenable) begin
                mask_reg[`VIC_MASK_GLOBAL] <= 1'b1;
            end
            // a grant wins the global bit but keeps the per-request bits just written
            if (ack_take) begin
                mask_reg[`VIC_MASK_GLOBAL] <= 1'b0;
            end
        end
    end

    // priority ranks, three bits per request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_reg <= `VIC_RST_PRIO;
        end else if (wr_req && (word_addr == {2'b00, `VIC_IDX_PRIO})) begin
            prio_reg <= pwdata[17:0];
        end
    end

    // comparator routing select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_comp_reg <= `VIC_RST_CFG;
        end else if (wr_req && (word_addr == {2'b00, `VIC_IDX_CFG})) begin
            cfg_comp_reg <= pwdata[`VIC_CFG_COMP];
        end
    end

    // ==========================================================
    // selection and vectoring
    assign enabled_vec = req_reg[NREQ-1:0] & mask_reg[NREQ-1:0]
        & {NREQ{mask_reg[`VIC_MASK_GLOBAL]}};

    vic_prio_enc #(.NREQ(NREQ)) u_prio (
        .req(enabled_vec),
        .ranks(prio_reg),
        .sel(sel_now)
    );

    // winner and its vector registered together; a grant clears the winner but not the vector, so they match while int_req is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg <= '0;
            vector_reg <= '0;
        end else begin
            sel_reg <= ack_take ? vic_sel_t'('0) : sel_now;
            vector_reg <= {12'h000, sel_now.idx, 1'b0};
        end
    end

    // one-cycle pulse telling the core to run the interrupt cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_reg <= 1'b0;
        end else begin
            cycle_reg <= ack_take;
        end
    end

    assign int_req = sel_reg.valid;
    assign vector_addr = vector_reg;
    assign int_cycle = cycle_reg;
    assign irq = |(req_reg[NREQ-1:0] & mask_reg[NREQ-1:0]);
    // no clock is gated here, so halt leaves every source live
    assign halt_wake = halt_active & (|enabled_vec);

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [NREQ-1:0] en_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= '0;
        end else begin
            en_q <= enabled_vec;
        end
    end

    a_event_latches: assert property ((evt_vec != '0) |=>
        ((req_reg[NREQ-1:0] & $past(evt_vec)) == $past(evt_vec)))
        else $error("event did not latch a pending bit");
    a_ack_clears_bit: assert property (ack_take && !evt_vec[sel_reg.idx] |=>
        !req_reg[$past(sel_reg.idx)])
        else $error("granted pending bit not cleared");
    a_ack_disables: assert property (ack_take |=> int_cycle && !int_req
        && !mask_reg[`VIC_MASK_GLOBAL] ##1 !int_cycle)
        else $error("grant did not disable interrupts for one cycle pulse");
    a_vector_pair: assert property (int_req |-> vector_addr == 16'(2 * sel_reg.idx))
        else $error("vector does not match granted request");
    a_winner_enabled: assert property (int_req |-> en_q[sel_reg.idx])
        else $error("granted request was not enabled");
    a_global_off: assert property (!mask_reg[`VIC_MASK_GLOBAL]
        ##1 !mask_reg[`VIC_MASK_GLOBAL] |-> !int_req)
        else $error("request presented while globally disabled");
    a_dsp_fall: assert property ($fell(dsp_request) |=> req_reg[`VIC_REQ_THREE])
        else $error("dsp falling edge lost");
    a_timer_req: assert property (timer_zero_end |=> req_reg[`VIC_REQ_FOUR])
        else $error("timer zero end of count lost");
    a_halt_wake: assert property (halt_active && (enabled_vec != '0) |-> halt_wake)
        else $error("enabled request did not wake halt");
    a_pin_rise: assert property (!cfg_comp_reg && edge_one_sel && !edge_two_sel
        && $rose(lvl_two) |=> req_reg[`VIC_REQ_TWO])
        else $error("rising edge on pin one lost");
endmodule : vic_top

// file: sim/vic_core_model.sv
// processor core model that takes vectors and returns from service
module vic_core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // controller side
    input wire logic int_req,
    input wire logic [15:0] vector_addr,
    input wire logic int_cycle,
    input wire logic [3:0] ack_wait,
    output logic int_ack,
    output logic int_reenable,
    // accepted vector, for the bench
    output logic taken,
    output logic [15:0] taken_vec
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_cnt;
    logic [2:0] ret_dly;
    // ==========================================================
    // acknowledge after a chosen wait, return four cycles after the cycle
    // a one-cycle ack pulse is enough because int_req stands until taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_ack <= 1'b0;
            int_reenable <= 1'b0;
            taken <= 1'b0;
            taken_vec <= 16'h0000;
            wait_cnt <= 4'h0;
            ret_dly <= 3'h0;
        end else begin
            taken <= int_ack & int_req;
            if (int_ack & int_req) begin
                taken_vec <= vector_addr;
            end
            int_ack <= int_req & ~int_ack & (wait_cnt >= ack_wait);
            wait_cnt <= (int_req & ~int_ack) ? wait_cnt + 4'h1 : 4'h0;
            ret_dly <= {ret_dly[1:0], int_cycle};
            int_reenable <= ret_dly[2];
        end
    end
endmodule : vic_core_model

// file: sim/vic_top_bench.sv
// self-checking bench of the vectored interrupt controller
`include "vic_map.svh"

module vic_top_bench;
    import vic_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] A_PIN = {2'h0, `VIC_IDX_PIN, 2'h0};
    localparam logic [11:0] A_PRIO = {2'h0, `VIC_IDX_PRIO, 2'h0};
    localparam logic [11:0] A_REQ = {2'h0, `VIC_IDX_REQ, 2'h0};
    localparam logic [11:0] A_MASK = {2'h0, `VIC_IDX_MASK, 2'h0};
    localparam logic [11:0] A_CFG = {2'h0, `VIC_IDX_CFG, 2'h0};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    vic_pins_t pins;
    logic dsp_request, timer_zero_end, timer_one_end, int_ack, int_reenable, halt_active;
    logic int_req, int_cycle, halt_wake, irq, taken;
    logic [15:0] vector_addr, taken_vec;
    logic [3:0] ack_wait;
    logic [33:0] exp_q[$];
    logic [15:0] exp_vec[$];
    logic [33:0] mon_e;
    logic [31:0] rnd = 32'h00010167;
    int num_errors = 0;
    int cmp_count = 0;

    vic_top vic_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pins, .dsp_request, .timer_zero_end, .timer_one_end,
        .int_ack, .int_reenable, .halt_active, .int_req, .vector_addr, .int_cycle,
        .halt_wake, .irq);
    vic_core_model vic_core_model_inst (.pclk, .presetn, .int_req, .vector_addr,
        .int_cycle, .ack_wait, .int_ack, .int_reenable, .taken, .taken_vec);

    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] lfsr_next();
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        return rnd;
    endfunction : lfsr_next

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // one apb transfer; the expectation is noted before the request goes out
    task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic err);
        exp_q.push_back({~is_wr, err, e});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= is_wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait-state count assumed; only the watchdog ends a stuck access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e, 1'b0);
    endtask : rd

    // make one event of request n, then put every line back to idle
    task automatic fire(input int n);
        @(posedge pclk);
        case (n)
            0: pins.port_pin_two <= 1'b0;
            1: pins.port_pin_three <= 1'b0;
            2: pins.port_pin_one <= 1'b0;
            3: dsp_request <= 1'b0;
            4: timer_zero_end <= 1'b1;
            default: timer_one_end <= 1'b1;
        endcase
        @(posedge pclk);
        timer_zero_end <= 1'b0;
        timer_one_end <= 1'b0;
        repeat (4) @(posedge pclk);
        pins <= 5'h1F;
        dsp_request <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : fire

    // bounded wait for all noted vectors to be taken, then for the return
    task automatic wait_vec();
        int n;
        n = 0;
        while (exp_vec.size() != 0 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(exp_vec.size()), 32'h0);
        repeat (6) @(posedge pclk);
    endtask : wait_vec

    // ==========================================================
    // clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        report_and_stop();
    end

    // ==========================================================
    // result watcher: oldest note against each completed result
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0) begin
            mon_e = exp_q.pop_front();
            if (mon_e[33]) chk(prdata, mon_e[31:0]);
            chk(32'(pslverr), 32'(mon_e[32]));
        end
        if (taken === 1'b1) begin
            chk({16'h0, taken_vec}, exp_vec.size() ? {16'h0, exp_vec.pop_front()} : 32'hFFFFFFFF);
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        int c;
        logic [31:0] r;
        logic [17:0] pr;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pins = 5'h1F;
        {dsp_request, timer_zero_end, timer_one_end, halt_active} = 4'h8;
        ack_wait = 4'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_PRIO, 32'h0002C688);
        rd(A_REQ, 32'h0);
        rd(A_MASK, 32'h0);
        rd(A_CFG, 32'h0);
        apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h004, 32'hFFFFFFFF, 32'h0, 1'b1);
        wr(A_MASK, 32'hFFFFFFFF);
        rd(A_MASK, 32'hBF);
        wr(A_CFG, 32'hFFFFFFFF);
        rd(A_CFG, 32'h1);
        wr(A_CFG, 32'h0);
        wr(A_REQ, 32'h3F);
        for (c = 0; c < 3; c++) begin
            r = lfsr_next();
            wr(A_PRIO, r);
            rd(A_PRIO, r & 32'h0003FFFF);
        end
        wr(A_PRIO, 32'h0002C688);
        // every source alone, core answering after a random wait
        wr(A_MASK, 32'hBF);
        for (c = 0; c < 6; c++) begin
            ack_wait <= 4'(lfsr_next());
            exp_vec.push_back(16'(2 * c));
            fire(c);
            wait_vec();
            rd(A_REQ, 32'h0);
        end
        // three pending while the global enable is off, ranks reversed
        wr(A_MASK, 32'h3F);
        for (c = 0; c < 6; c++) pr[3 * c +: 3] = 3'(5 - c);
        wr(A_PRIO, {14'h0, pr});
        fire(3);
        fire(4);
        fire(5);
        rd(A_REQ, 32'h38);
        @(negedge pclk);
        chk({30'h0, irq, int_req}, 32'h2);
        exp_vec.push_back(16'hA);
        exp_vec.push_back(16'h8);
        exp_vec.push_back(16'h6);
        wr(A_MASK, 32'hBF);
        wait_vec();
        wr(A_PRIO, 32'h0002C688);
        // level output: raise, mask, unmask, clear
        wr(A_MASK, 32'h10);
        fire(4);
        chk(32'(irq), 32'h1);
        wr(A_MASK, 32'h0);
        @(negedge pclk);
        chk(32'(irq), 32'h0);
        wr(A_MASK, 32'h10);
        @(negedge pclk);
        chk(32'(irq), 32'h1);
        wr(A_REQ, 32'h10);
        @(negedge pclk);
        chk(32'(irq), 32'h0);
        // halted core woken while a slow ack is pending
        halt_active <= 1'b1;
        ack_wait <= 4'hC;
        wr(A_MASK, 32'hBF);
        @(negedge pclk);
        chk(32'(halt_wake), 32'h0);
        exp_vec.push_back(16'hA);
        @(posedge pclk) timer_one_end <= 1'b1;
        @(posedge pclk) timer_one_end <= 1'b0;
        repeat (3) @(negedge pclk);
        chk({30'h0, halt_wake, int_req}, 32'h3);
        wait_vec();
        halt_active <= 1'b0;
        // every edge code, falling then rising, polled only
        wr(A_MASK, 32'h0);
        for (c = 0; c < 4; c++) begin
            wr(A_REQ, {24'h0, 2'(c), 6'h3F});
            @(posedge pclk);
            pins.port_pin_one <= 1'b0;
            pins.port_pin_two <= 1'b0;
            repeat (5) @(posedge pclk);
            rd(A_PIN, 32'h9);
            rd(A_REQ, {24'h0, 2'(c), 3'h0, 1'(c != 2), 1'b0, 1'(c != 1)});
            wr(A_REQ, {24'h0, 2'(c), 6'h3F});
            @(posedge pclk);
            pins <= 5'h1F;
            repeat (5) @(posedge pclk);
            rd(A_PIN, 32'hF);
            rd(A_REQ, {24'h0, 2'(c), 3'h0, 1'(c >= 2), 1'b0, 1'(c % 2)});
        end
        // comparators steered into requests two and zero
        wr(A_CFG, 32'h1);
        wr(A_REQ, 32'h3F);
        @(posedge pclk);
        pins.comparator_one_out <= 1'b0;
        pins.comparator_two_out <= 1'b0;
        repeat (5) @(posedge pclk);
        rd(A_PIN, 32'h9);
        rd(A_REQ, 32'h05);
        pins <= 5'h1F;
        repeat (5) @(posedge pclk);
        wr(A_CFG, 32'h0);
        repeat (4) @(posedge pclk);
        report_and_stop();
    end
endmodule : vic_top_bench
